/* include/ccu_defines.svh */
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// Register map, byte addresses
`define CCU_VAL_BASE 12'h000
`define CCU_CFG_BASE 12'h080
`define CCU_TCTL_BASE 12'h100
`define CCU_TVAL_BASE 12'h110
`define CCU_TREL_BASE 12'h120
`define CCU_IRQ_STAT 12'h130
`define CCU_IRQ_MASK 12'h134

// Address decode slices
`define CCU_BANK_HI 11
`define CCU_BANK_LO 7
`define CCU_BANK_VAL 5'h00
`define CCU_BANK_CFG 5'h01
`define CCU_TBANK_HI 11
`define CCU_TBANK_LO 4

// Channel configuration fields
`define CCU_CFG_W 8
`define CCU_CFG_FUNC_HI 2
`define CCU_CFG_FUNC_LO 0
`define CCU_CFG_TSEL 3
`define CCU_CFG_EDGE_HI 5
`define CCU_CFG_EDGE_LO 4
`define CCU_CFG_SINGLE 6
`define CCU_CFG_DOUBLE 7
`define CCU_EDGE_RISE 0
`define CCU_EDGE_FALL 1

// Timer control fields
`define CCU_TCTL_W 4
`define CCU_TCTL_RUN 0
`define CCU_TCTL_SEL_HI 3
`define CCU_TCTL_SEL_LO 1

// Timing
`define CCU_PRE_W 9
`define CCU_PRE_STEP 3
`define CCU_TMR_MAX 16'hFFFF

// Reset values
`define CCU_CFG_RST 8'h00
`define CCU_TCTL_RST 4'h0
`define CCU_WORD_RST 32'h0000_0000
`define CCU_HALF_RST 16'h0000

// AXI responses
`define CCU_RESP_OKAY 2'b00
`define CCU_RESP_SLVERR 2'b10

`endif

/* include/ccu_pkg.sv */
package ccu_pkg;

   // Channel function
   typedef enum logic [2:0] {
      FUNC_OFF = 3'h0,
      FUNC_CAPTURE = 3'h1,
      FUNC_CMP0 = 3'h4,
      FUNC_CMP1 = 3'h5,
      FUNC_CMP2 = 3'h6,
      FUNC_CMP3 = 3'h7
   } cc_func_t;

   // Timer count source
   typedef enum logic [2:0] {
      CLK_DIV1 = 3'h0,
      CLK_DIV8 = 3'h1,
      CLK_DIV64 = 3'h2,
      CLK_DIV512 = 3'h3,
      CLK_GP_OVF = 3'h4,
      CLK_EXT = 3'h5
   } cnt_src_t;

endpackage : ccu_pkg

/* rtl/dual_array_capture_compare.sv */
// How it works
// R1: Thirty-two channels, one-cycle or eight-cycle resolution.
// R2: Two reloadable 16-bit timers per array.
// R3: Timer clock: prescaled system clock or gp overflow.
// R4: First timer of each array counts external events.
// R5: Sixteen registers per array, timer and function selectable.
// R6: Twelve array-two registers own one port pin.
// R7: Mode 0: interrupt only, every match.
// R8: Mode 1: pin toggles on every match.
// R9: Mode 2: interrupt only, once per period.
// R10: Mode 3: set on match, clear on overflow.
// R11: Double register: two registers toggle one pin.
// R12: Single event option disarms after one action.
// R13: Capture latches assigned timer on pin event.
// R14: Each capture raises its own interrupt request.
// R15: Capture edge: rising, falling or both.
// R16: Compare runs on every timer update.
// R17: Match performs the configured mode's action.
// R18: Overflow reloads timer from its reload register.
// R19: Outside signals stay stable long enough to sample.
`timescale 1ns/1ns
`include "ccu_defines.svh"

module dual_array_capture_compare
   import ccu_pkg::*;
#(
   parameter int NCH = 16,
   parameter int NPIN = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Count sources
   input wire logic gp_ovf_pulse,
   input wire logic [1:0] ext_count_in,
   // Array-two port pins
   input wire logic [NPIN-1:0] cc_pin_in,
   output logic [NPIN-1:0] cc_pin_out,
   output logic [NPIN-1:0] cc_pin_oe,
   // Interrupt
   output logic irq
);

   localparam int NTOT = 2 * NCH;
   localparam int NTMR = 4;

   logic [15:0] val_r [NTOT];
   logic [`CCU_CFG_W-1:0] cfg_r [NTOT];
   logic [`CCU_TCTL_W-1:0] tctl_r [NTMR];
   logic [15:0] tmr_r [NTMR];
   logic [15:0] rel_r [NTMR];
   logic [NTOT-1:0] stat_r;
   logic [NTOT-1:0] mask_r;
   logic [NTOT-1:0] done_r;
   logic [NCH-1:0] out_r;
   logic [NTMR-1:0] upd_r;
   logic [`CCU_PRE_W-1:0] pre_r;
   logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_d_r;
   logic [1:0] ext_s1_r, ext_s2_r, ext_d_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   logic [NTMR-1:0] tick, ovf;
   logic [NTOT-1:0] match, act, cap_ev;
   logic [NCH-1:0] out_nxt;
   logic wr_fire, rd_fire;
   logic [31:0] rdata_nxt;
   logic rd_err;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic cc_func_t func_of(input logic [`CCU_CFG_W-1:0] cfg);
      return cc_func_t'(cfg[`CCU_CFG_FUNC_HI:`CCU_CFG_FUNC_LO]);
   endfunction : func_of

   function automatic logic is_cmp(input logic [`CCU_CFG_W-1:0] cfg);
      return cfg[`CCU_CFG_FUNC_HI];
   endfunction : is_cmp

   function automatic int tmr_of(input int c, input logic [`CCU_CFG_W-1:0] cfg);
      return 2 * (c / NCH) + int'(cfg[`CCU_CFG_TSEL]);
   endfunction : tmr_of

   // Write address and data are taken together; no write outstanding
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;
   assign rd_fire = s_axi_arvalid && !rvalid_r;
   assign s_axi_arready = rd_fire;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   function automatic logic wr_hit(input logic [11:0] base);
      return wr_fire && (s_axi_awaddr[11:2] == base[11:2]);
   endfunction : wr_hit

   // Pins and external count inputs pass two flops before use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_d_r <= '0;
         ext_s1_r <= '0;
         ext_s2_r <= '0;
         ext_d_r <= '0;
      end else begin
         pin_s1_r <= cc_pin_in; // R19
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
         ext_s1_r <= ext_count_in; // R19
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_s2_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // Count enables per timer
   always_comb begin
      for (int t = 0; t < NTMR; t++) begin
         logic [`CCU_PRE_W-1:0] pm;
         cnt_src_t src;
         pm = '0;
         src = cnt_src_t'(tctl_r[t][`CCU_TCTL_SEL_HI:`CCU_TCTL_SEL_LO]);
         unique case (src)
            CLK_DIV1: tick[t] = 1'b1; // R1
            CLK_DIV8: begin
               pm = `CCU_PRE_W'((1 << `CCU_PRE_STEP) - 1);
               tick[t] = (pre_r & pm) == '0; // R1 R3
            end
            CLK_DIV64: begin
               pm = `CCU_PRE_W'((1 << (2 * `CCU_PRE_STEP)) - 1);
               tick[t] = (pre_r & pm) == '0; // R3
            end
            CLK_DIV512: tick[t] = pre_r == '0; // R3
            CLK_GP_OVF: tick[t] = gp_ovf_pulse; // R3
            CLK_EXT: tick[t] = (t % 2 == 0) && ext_s2_r[t/2] && !ext_d_r[t/2]; // R4
            default: tick[t] = 1'b0;
         endcase
         tick[t] = tick[t] && tctl_r[t][`CCU_TCTL_RUN];
         ovf[t] = tick[t] && (tmr_r[t] == `CCU_TMR_MAX);
      end
   end

   // Timers, reload registers and timer control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int t = 0; t < NTMR; t++) begin
            tmr_r[t] <= `CCU_HALF_RST;
            rel_r[t] <= `CCU_HALF_RST;
            tctl_r[t] <= `CCU_TCTL_RST;
         end
         upd_r <= '0;
      end else begin
         for (int t = 0; t < NTMR; t++) begin
            upd_r[t] <= tick[t]; // R16
            if (wr_hit(`CCU_TVAL_BASE + 12'(4 * t))) begin
               tmr_r[t] <= 16'(merge(32'(tmr_r[t]), s_axi_wdata, s_axi_wstrb));
            end else if (ovf[t]) begin
               tmr_r[t] <= rel_r[t]; // R18
            end else if (tick[t]) begin
               tmr_r[t] <= tmr_r[t] + 16'h0001; // R2
            end
            if (wr_hit(`CCU_TREL_BASE + 12'(4 * t))) begin
               rel_r[t] <= 16'(merge(32'(rel_r[t]), s_axi_wdata, s_axi_wstrb)); // R2
            end
            if (wr_hit(`CCU_TCTL_BASE + 12'(4 * t))) begin
               tctl_r[t] <= `CCU_TCTL_W'(merge(32'(tctl_r[t]), s_axi_wdata, s_axi_wstrb));
            end
         end
      end
   end

   // Per-channel match, action and capture event
   always_comb begin
      for (int c = 0; c < NTOT; c++) begin
         int t;
         int j;
         logic rise, fall;
         t = tmr_of(c, cfg_r[c]);
         j = c - NCH;
         rise = 1'b0;
         fall = 1'b0;
         if (c >= NCH && j < NPIN) begin
            rise = pin_s2_r[j] && !pin_d_r[j];
            fall = !pin_s2_r[j] && pin_d_r[j];
         end
         // Compared on every update of the assigned timer
         match[c] = is_cmp(cfg_r[c]) && upd_r[t] && (tmr_r[t] == val_r[c]); // R16 R17
         unique case (func_of(cfg_r[c]))
            FUNC_CMP0, FUNC_CMP1: act[c] = match[c]; // R7 R8
            FUNC_CMP2, FUNC_CMP3: act[c] = match[c] && !done_r[c]; // R9 R10
            default: act[c] = 1'b0;
         endcase
         cap_ev[c] = (func_of(cfg_r[c]) == FUNC_CAPTURE) && // R13
            ((cfg_r[c][`CCU_CFG_EDGE_LO + `CCU_EDGE_RISE] && rise) || // R15
             (cfg_r[c][`CCU_CFG_EDGE_LO + `CCU_EDGE_FALL] && fall)); // R15
      end
   end

   // Array-two pin levels
   always_comb begin
      out_nxt = out_r;
      for (int j = 0; j < NCH; j++) begin
         int c;
         int p;
         c = NCH + j;
         p = c;
         unique case (func_of(cfg_r[c]))
            FUNC_CMP1: begin
               if (act[c]) begin
                  out_nxt[j] = !out_nxt[j]; // R8
               end
            end
            FUNC_CMP3: begin
               if (ovf[tmr_of(c, cfg_r[c])]) begin
                  out_nxt[j] = 1'b0; // R10
               end
               if (act[c]) begin
                  out_nxt[j] = 1'b1; // R10
               end
            end
            default: out_nxt[j] = out_nxt[j];
         endcase
         // Upper half of a pair toggles the lower register's pin
         if (j < NCH / 2) begin
            p = c + NCH / 2;
            if (cfg_r[c][`CCU_CFG_DOUBLE] && act[p]) begin
               out_nxt[j] = !out_nxt[j]; // R11
            end
            if (cfg_r[c][`CCU_CFG_DOUBLE] && act[c] && func_of(cfg_r[c]) != FUNC_CMP1) begin
               out_nxt[j] = !out_nxt[j]; // R11
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_r <= '0;
      end else begin
         out_r <= out_nxt; // R6
      end
   end

   always_comb begin
      for (int j = 0; j < NPIN; j++) begin
         cc_pin_out[j] = out_r[j]; // R6
         cc_pin_oe[j] = func_of(cfg_r[NCH + j]) == FUNC_CMP1 || func_of(cfg_r[NCH + j]) == FUNC_CMP3 ||
            cfg_r[NCH + j][`CCU_CFG_DOUBLE];
      end
   end

   // Once-per-period latch, released by the assigned timer's overflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= '0;
      end else begin
         for (int c = 0; c < NTOT; c++) begin
            if (act[c]) begin
               done_r[c] <= 1'b1; // R9 R10
            end else if (ovf[tmr_of(c, cfg_r[c])] || !is_cmp(cfg_r[c])) begin
               done_r[c] <= 1'b0;
            end
         end
      end
   end

   // Channel values and configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < NTOT; c++) begin
            val_r[c] <= `CCU_HALF_RST;
            cfg_r[c] <= `CCU_CFG_RST;
         end
      end else begin
         for (int c = 0; c < NTOT; c++) begin
            if (cap_ev[c]) begin
               val_r[c] <= tmr_r[tmr_of(c, cfg_r[c])]; // R13
            end else if (wr_hit(`CCU_VAL_BASE + 12'(4 * c))) begin
               val_r[c] <= 16'(merge(32'(val_r[c]), s_axi_wdata, s_axi_wstrb));
            end
            // Hardware disarm wins over a same-cycle write
            if (act[c] && cfg_r[c][`CCU_CFG_SINGLE]) begin
               cfg_r[c][`CCU_CFG_FUNC_HI:`CCU_CFG_FUNC_LO] <= FUNC_OFF; // R12
            end else if (wr_hit(`CCU_CFG_BASE + 12'(4 * c))) begin
               cfg_r[c] <= `CCU_CFG_W'(merge(32'(cfg_r[c]), s_axi_wdata, s_axi_wstrb)); // R5
            end
         end
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         stat_r <= (stat_r & ~(wr_hit(`CCU_IRQ_STAT) ? merge(`CCU_WORD_RST, s_axi_wdata, s_axi_wstrb) :
            `CCU_WORD_RST)) | cap_ev | act; // R7 R9 R14
         if (wr_hit(`CCU_IRQ_MASK)) begin
            mask_r <= merge(mask_r, s_axi_wdata, s_axi_wstrb);
         end
      end
   end

   assign irq = |(stat_r & mask_r);

   // Read decode
   always_comb begin
      logic [11:0] a;
      a = s_axi_araddr;
      rdata_nxt = `CCU_WORD_RST;
      rd_err = 1'b0;
      if (a[`CCU_BANK_HI:`CCU_BANK_LO] == `CCU_BANK_VAL) begin
         rdata_nxt = 32'(val_r[a[6:2]]);
      end else if (a[`CCU_BANK_HI:`CCU_BANK_LO] == `CCU_BANK_CFG) begin
         rdata_nxt = 32'(cfg_r[a[6:2]]);
      end else if ((a >> `CCU_TBANK_LO) == (`CCU_TCTL_BASE >> `CCU_TBANK_LO)) begin
         rdata_nxt = 32'(tctl_r[a[3:2]]);
      end else if ((a >> `CCU_TBANK_LO) == (`CCU_TVAL_BASE >> `CCU_TBANK_LO)) begin
         rdata_nxt = 32'(tmr_r[a[3:2]]);
      end else if ((a >> `CCU_TBANK_LO) == (`CCU_TREL_BASE >> `CCU_TBANK_LO)) begin
         rdata_nxt = 32'(rel_r[a[3:2]]);
      end else if (a[11:2] == 10'(`CCU_IRQ_STAT >> 2)) begin
         rdata_nxt = stat_r;
      end else if (a[11:2] == 10'(`CCU_IRQ_MASK >> 2)) begin
         rdata_nxt = mask_r;
      end else begin
         rd_err = 1'b1;
      end
   end

   function automatic logic wr_mapped(input logic [11:0] a);
      // Every word up to the mask register is mapped, status included
      return a[11:2] <= 10'(`CCU_IRQ_MASK >> 2);
   endfunction : wr_mapped

   // Bus responses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `CCU_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped(s_axi_awaddr) ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= `CCU_RESP_OKAY;
         rdata_r <= `CCU_WORD_RST;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_err ? `CCU_RESP_SLVERR : `CCU_RESP_OKAY;
         rdata_r <= rdata_nxt;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule : dual_array_capture_compare

/* testbench/ccu_checker_asserts.sv */
`timescale 1ns/1ns
module ccu_checker #(
   parameter int NPIN = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and interrupt
   input wire logic [NPIN-1:0] cc_pin_out,
   input wire logic [NPIN-1:0] cc_pin_oe,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && !s_axi_rvalid;
   endsequence
   property p_wr_resp;
      s_wr_take |=> s_axi_bvalid;
   endproperty
   property p_wr_ready;
      (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) && (s_axi_wready == s_axi_awready);
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_b_cause;
      $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_wvalid);
   endproperty
   property p_rd_resp;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   property p_rd_ready;
      s_axi_arready == (s_axi_arvalid && !s_axi_rvalid);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_reset_out;
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && cc_pin_out == '0;
   endproperty
   // A pin that is not driven must never move
   property p_pin_driven;
      ((cc_pin_out ^ $past(cc_pin_out)) & ~(cc_pin_oe | $past(cc_pin_oe))) == '0;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
   a_wr_ready: assert property (p_wr_ready) else $error("write ready wrong");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   a_b_cause: assert property (p_b_cause) else $error("write response without request");
   a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
   a_rd_ready: assert property (p_rd_ready) else $error("read ready wrong");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
   a_pin_driven: assert property (p_pin_driven) else $error("undriven pin moved");
endmodule : ccu_checker

bind dual_array_capture_compare ccu_checker #(.NPIN(NPIN)) u_chk (.*);

/* testbench/port_pin_model.sv */
`timescale 1ns/1ns
module port_pin_model (
   // Clock
   input wire logic aclk,
   // Levels asked for by the bench
   input wire logic [11:0] pin_req,
   input wire logic [1:0] ext_req,
   // Lines into the block
   output logic [11:0] cc_pin_in,
   output logic [1:0] ext_count_in
);
   logic [1:0] hold_r = 2'h0;
   logic [11:0] pin_r = 12'h000;
   logic [1:0] ext_r = 2'h0;
   // Lines move on a four-cycle grid only, so no level is shorter than the sampling needs
   always_ff @(posedge aclk) begin
      hold_r <= hold_r + 2'h1;
      if (hold_r == 2'h3) begin
         pin_r <= pin_req;
         ext_r <= ext_req;
      end
   end
   assign cc_pin_in = pin_r;
   assign ext_count_in = ext_r;
endmodule : port_pin_model

/* testbench/test_dual_array_capture_compare.sv */
`timescale 1ns/1ns
`include "ccu_defines.svh"
module test_dual_array_capture_compare
   import ccu_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, gp_ovf_pulse = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, ext_count_in, ext_req = 2'h0;
   logic [11:0] cc_pin_in, cc_pin_out, cc_pin_oe, pin_req = 12'h000;
   int errors = 0, total_checks = 0, cyc = 0;

   dual_array_capture_compare #(.NCH(16), .NPIN(12)) DUT (.*);
   port_pin_model PM (.*);

   always #5 aclk = ~aclk;

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge aclk) begin
      cyc++;
      if (cyc > 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (s_axi_awready !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      while (s_axi_bvalid !== 1'h1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
   endtask : rd

   task automatic w(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(`CCU_RESP_OKAY));
   endtask : w

   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d & m, e);
   endtask : rchk

   function automatic logic [11:0] ad(input logic [11:0] b, input int i);
      return b + 12'(4 * i);
   endfunction : ad

   function automatic logic [31:0] cf(input cc_func_t f, input logic [7:0] x);
      return {24'h0, x | {5'h0, f}};
   endfunction : cf

   // Ticks in one timer period at a given reload value
   function automatic int per(input logic [15:0] rl);
      return 32'h10000 - int'(rl);
   endfunction : per

   task automatic wpin(input int b, output int t);
      logic v;
      v = cc_pin_out[b];
      t = 0;
      do begin
         @(posedge aclk);
         t++;
      end while (cc_pin_out[b] === v && t < 3000);
   endtask : wpin

   task automatic cnt(input int b, input int n, output int k);
      logic v;
      k = 0;
      v = cc_pin_out[b];
      repeat (n) begin
         @(posedge aclk);
         if (cc_pin_out[b] !== v) k++;
         v = cc_pin_out[b];
      end
   endtask : cnt

   // Capture channel 20 sits on pin 4 and the second timer of array B
   task automatic cap(input logic lvl, input logic [15:0] tv, input logic [15:0] e);
      w(ad(`CCU_TVAL_BASE, 3), {16'h0, tv});
      pin_req[4] <= lvl;
      repeat (12) @(posedge aclk);
      rchk(ad(`CCU_VAL_BASE, 20), 32'h0000_FFFF, {16'h0, e});
   endtask : cap

   initial begin
      logic [15:0] rl, v1, v3, vd, vs, x, y;
      logic [31:0] d;
      logic [1:0] r;
      int t, k, p, n, m;
      void'($urandom(97));
      rl = 16'hFFE0 + 16'($urandom % 16);
      p = per(rl);
      v1 = rl + 16'h1 + 16'($urandom % 15);
      v3 = rl + 16'h1 + 16'($urandom % 15);
      vd = rl + 16'h1 + 16'($urandom % 7);
      vs = rl + 16'h1 + 16'($urandom % 15);
      x = 16'($urandom);
      y = ~x;
      n = 1 + $urandom % 5;
      m = 1 + $urandom % 5;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rchk(ad(`CCU_CFG_BASE, 5), 32'hFFFF_FFFF, `CCU_WORD_RST);
      rchk(ad(`CCU_TCTL_BASE, 2), 32'hFFFF_FFFF, `CCU_WORD_RST);
      rd(12'h200, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(`CCU_RESP_SLVERR));
      wr(12'h200, 32'hFFFF_FFFF, r);
      chk(32'(r), 32'(`CCU_RESP_SLVERR));
      w(ad(`CCU_TREL_BASE, 2), {16'h0, rl});
      w(ad(`CCU_TVAL_BASE, 2), {16'h0, rl});
      w(ad(`CCU_VAL_BASE, 16), {16'h0, v1});
      w(ad(`CCU_CFG_BASE, 16), cf(FUNC_CMP1, 8'h00));
      w(ad(`CCU_VAL_BASE, 17), {16'h0, v3});
      w(ad(`CCU_CFG_BASE, 17), cf(FUNC_CMP3, 8'h00));
      w(ad(`CCU_VAL_BASE, 18), {16'h0, vd});
      w(ad(`CCU_CFG_BASE, 18), cf(FUNC_CMP1, 8'h80));
      w(ad(`CCU_VAL_BASE, 26), {16'h0, vd + 16'h8});
      w(ad(`CCU_CFG_BASE, 26), cf(FUNC_CMP0, 8'h00));
      w(ad(`CCU_VAL_BASE, 19), {16'h0, vs});
      w(ad(`CCU_CFG_BASE, 19), cf(FUNC_CMP1, 8'h40));
      chk(32'(cc_pin_oe[4:0]), 32'h0000_000F);
      w(ad(`CCU_TCTL_BASE, 2), 32'h1);
      wpin(0, t);
      wpin(0, t);
      chk(32'(t), 32'(p));
      wpin(1, t);
      if (cc_pin_out[1] !== 1'h1) wpin(1, t);
      wpin(1, t);
      // Set lags the timer by the compare stage, the overflow clear does not
      chk(32'(t), 32'hFFFF - {16'h0, v3});
      cnt(2, 2 * p, k);
      chk(32'(k), 32'h4);
      chk(32'(cc_pin_out[3]), 32'h1);
      rchk(ad(`CCU_CFG_BASE, 19), 32'h7, 32'h0);
      cnt(3, 2 * p, k);
      chk(32'(k), 32'h0);
      rchk(`CCU_IRQ_STAT, 32'h0400_0000, 32'h0400_0000);
      // Array A: first timer on outside events, second on general timer overflows
      w(ad(`CCU_VAL_BASE, 0), 32'(n));
      w(ad(`CCU_CFG_BASE, 0), cf(FUNC_CMP0, 8'h00));
      w(ad(`CCU_VAL_BASE, 1), 32'(m));
      w(ad(`CCU_CFG_BASE, 1), cf(FUNC_CMP2, 8'h08));
      w(`CCU_IRQ_MASK, 32'h1);
      w(ad(`CCU_TCTL_BASE, 0), 32'hB);
      w(ad(`CCU_TCTL_BASE, 1), 32'h9);
      repeat (n) begin
         ext_req[0] <= 1'h1;
         repeat (8) @(posedge aclk);
         ext_req[0] <= 1'h0;
         repeat (8) @(posedge aclk);
      end
      repeat (m) begin
         gp_ovf_pulse <= 1'h1;
         @(posedge aclk);
         gp_ovf_pulse <= 1'h0;
         @(posedge aclk);
      end
      repeat (8) @(posedge aclk);
      rchk(ad(`CCU_TVAL_BASE, 0), 32'hFFFF_FFFF, 32'(n));
      rchk(ad(`CCU_TVAL_BASE, 1), 32'hFFFF_FFFF, 32'(m));
      rchk(`CCU_IRQ_STAT, 32'h3, 32'h3);
      chk(32'(irq), 32'h1);
      w(`CCU_IRQ_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      w(`CCU_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      w(`CCU_IRQ_STAT, 32'h3);
      rchk(`CCU_IRQ_STAT, 32'h3, 32'h0);
      chk(32'(irq), 32'h0);
      w(ad(`CCU_CFG_BASE, 20), cf(FUNC_CAPTURE, 8'h18));
      cap(1'h1, x, x);
      rchk(`CCU_IRQ_STAT, 32'h0010_0000, 32'h0010_0000);
      cap(1'h0, y, x);
      w(ad(`CCU_CFG_BASE, 20), cf(FUNC_CAPTURE, 8'h38));
      cap(1'h1, y, y);
      cap(1'h0, x, x);
      // Array B second timer on the prescaler: the pin period stretches by the division
      w(ad(`CCU_TREL_BASE, 3), {16'h0, rl});
      w(ad(`CCU_TVAL_BASE, 3), {16'h0, rl});
      w(ad(`CCU_VAL_BASE, 21), {16'h0, v1});
      w(ad(`CCU_CFG_BASE, 21), cf(FUNC_CMP1, 8'h08));
      w(ad(`CCU_TCTL_BASE, 3), 32'h3);
      wpin(5, t);
      wpin(5, t);
      chk(32'(t), 32'(p << `CCU_PRE_STEP));
      w(ad(`CCU_TCTL_BASE, 3), 32'h5);
      wpin(5, t);
      wpin(5, t);
      chk(32'(t), 32'(p << (2 * `CCU_PRE_STEP)));
      tally_and_finish();
   end
endmodule : test_dual_array_capture_compare
